// ==== test/ascca_station.sv ====
`default_nettype none
// Far-side station: one character report per send request
module ascca_station (
  input  wire logic                 i_clk,
  input  wire logic                 i_send,   // One character arrives
  input  wire logic                 i_mp_bit, // Its multiprocessor bit
  input  wire logic [2:0]           i_err,    // Overrun, parity, framing
  input  wire logic                 i_mp_fmt, // Multiprocessor frame in use
  output var  ascca_pkg::ascca_rxev_t o_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  // Report lasts one cycle; an mp frame has no parity bit to fail
  always_ff @(posedge i_clk) begin
    o_ev <= '{i_send, i_mp_bit, i_err[2], i_err[1] & !i_mp_fmt, i_err[0]};
  end
endmodule // ascca_station
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, pen, pwr, halt, send, multiproc_bit, mpf, dma, c1o, c1oe, c1pi, er;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [2:0]  err;
  wire         rdy, slv, pin_o, pin_oe, c1_in, rts_n, irq;
  wire  [1:0]  rx_en, tx_en;
  ascca_pkg::ascca_fmt_t  fmt [2];
  ascca_pkg::ascca_rxev_t ev0;
  wire ascca_pkg::ascca_rxev_t rx_ev [2];
  int          mismatches, checks;
  // Rows: written control A value, then {0, rx, tx, rts, format}
  logic [15:0] rows [8] = '{16'h4040, 16'h2122, 16'h1214, 16'h6366,
                            16'h7478, 16'h050a, 16'h565c, 16'h373e};
  wire  [7:0]  outs = {1'b0, rx_en[0], tx_en[0], rts_n, fmt[0]};
  assign rx_ev[0] = ev0;
  assign rx_ev[1] = ev0;  // Channel 1 hears the same line; its receiver stays off
  ascca_top dut (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
    .O_PSLVERR(slv), .I_IO_HALT(halt), .I_RX_EV(rx_ev), .I_DMA_END(dma),
    .I_CLK1_OUT(c1o), .I_CLK1_OE(c1oe), .I_CLK1_PIN_I(c1pi), .O_CLK1_PIN_O(pin_o),
    .O_CLK1_PIN_OE(pin_oe), .O_CLK1_IN(c1_in), .O_REQUEST_TO_SEND_CH0_N(rts_n), .O_RX_EN(rx_en),
    .O_TX_EN(tx_en), .O_FMT(fmt), .O_IRQ(irq));
  ascca_station station (.i_clk(clk), .i_send(send), .i_mp_bit(multiproc_bit), .i_err(err),
    .i_mp_fmt(mpf), .o_ev(ev0));
  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen  <= 1'b0;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prd;
    er = slv;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask
  // Write, then let control outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // One character from the station, then time for flags to land
  task automatic chr(input logic m, input logic [2:0] e);
    @(posedge clk);
    send <= 1'b1;
    multiproc_bit  <= m;
    err  <= e;
    @(posedge clk);
    send <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    {rst, psel, pen, pwr, halt, send, multiproc_bit, mpf, dma, c1o, c1oe, c1pi} = 12'h800;
    pa = '0;
    pwd = '0;
    err = '0;
    repeat (2) @(posedge clk);
    chk({31'h0, rts_n}, 32'h1);
    chk({30'h0, rx_en[0], tx_en[0]}, 32'h0);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'hf7, 32'h10);
    rc(12'h004, 32'h0);
    foreach (rows[i]) begin
      wr(12'h000, {24'h0, rows[i][15:8]});
      chk({24'h0, outs}, {24'h0, rows[i][7:0]});
      rc(12'h000, {24'h0, rows[i][15:8]});
    end
    // Flags, hold on disable, error clear, interrupt
    wr(12'h014, 32'hff);
    wr(12'h000, 32'h40);
    chr(1'b0, 3'b101);
    rc(12'h018, 32'h0b);
    chk({31'h0, irq}, 32'h1);
    wr(12'h000, 32'h08);
    rc(12'h018, 32'h0b);
    wr(12'h000, 32'h40);
    rc(12'h018, 32'h01);
    wr(12'h010, 32'hff);
    chk({31'h0, irq}, 32'h0);
    // Wake-up filter in multiprocessor format
    wr(12'h008, 32'h40);
    mpf <= 1'b1;
    wr(12'h000, 32'hc8);
    chk({28'h0, fmt[0]}, 32'h1);
    chr(1'b0, 3'b100);
    rc(12'h018, 32'h01);
    chr(1'b1, 3'b001);
    rc(12'h018, 32'h09);
    rc(12'h000, 32'hc8);
    wr(12'h008, 32'h0);
    mpf <= 1'b0;
    wr(12'h000, 32'hc0);
    chr(1'b0, 3'b100);
    rc(12'h018, 32'h03);
    // Masked event stays quiet until unmasked
    wr(12'h010, 32'hff);
    wr(12'h014, 32'h0);
    chr(1'b0, 3'b001);
    chk({31'h0, irq}, 32'h0);
    wr(12'h014, 32'hff);
    chk({31'h0, irq}, 32'h1);
    // I/O halt forces both enables off
    wr(12'h000, 32'h60);
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    chk({30'h0, rx_en[0], tx_en[0]}, 32'h0);
    halt <= 1'b0;
    // Channel 1 shared pin selection
    dma <= 1'b1;
    wr(12'h004, 32'h10);
    chk({30'h0, pin_o, pin_oe}, 32'h3);
    chk({31'h0, rts_n}, 32'h0);
    c1oe <= 1'b1;
    c1pi <= 1'b1;
    wr(12'h004, 32'h00);
    chk({29'h0, pin_o, pin_oe, c1_in}, 32'h3);
    // Unmapped place is refused
    apb(1'b1, 12'h040, 32'hff);
    chk({31'h0, er}, 32'h1);
    rc(12'h040, 32'h0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire

// ==== verilog/ascca_pkg.sv ====
`default_nettype none
package ascca_pkg;
  // Register indices on APB; the byte address is index * 4
  localparam logic [7:0] CTRL_A_CH0_IDX  = 8'h00;
  localparam logic [7:0] CTRL_A_CH1_IDX  = 8'h01;
  localparam logic [7:0] CTRL_B_CH0_IDX  = 8'h02;
  localparam logic [7:0] CTRL_B_CH1_IDX  = 8'h03;
  localparam logic [7:0] INT_STAT_IDX    = 8'h04;
  localparam logic [7:0] INT_MASK_IDX    = 8'h05;
  localparam logic [7:0] RX_FLAGS_IDX    = 8'h06;
  localparam int         ADDR_W          = 12;
  // Control register A field positions
  localparam int BIT_WAKE  = 7;
  localparam int BIT_RXEN  = 6;
  localparam int BIT_TXEN  = 5;
  localparam int BIT_PIN4  = 4;
  localparam int BIT_MPB   = 3;
  localparam int BIT_FMT_H = 2;
  // Control register B: multiprocessor format bit
  localparam int BIT_MPSEL = 6;
  // Reset values (bit 3 undefined, held at zero here)
  localparam logic [7:0] CTRL_A_CH0_RST = 8'h10;
  localparam logic [7:0] CTRL_A_CH1_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST     = 8'h00;
  // Per-channel flag layout: receive full, overrun, parity, framing
  localparam int FLG_RDF = 0;
  localparam int FLG_OVR = 1;
  localparam int FLG_PAR = 2;
  localparam int FLG_FRM = 3;
  localparam int NFLG    = 4;
  // Received character report from the shift datapath
  typedef struct packed {
    logic valid;
    logic mp_bit;
    logic overrun;
    logic parity_err;
    logic framing_err;
  } ascca_rxev_t;
  // Frame format decoded for the datapath
  typedef struct packed {
    logic eight_bits;
    logic parity_on;
    logic two_stops;
    logic mp_frame;
  } ascca_fmt_t;
endpackage
`default_nettype wire

// ==== verilog/ascca_top.sv ====
// Behaviour
// - Receiver enable bit 6 enables receiver
// - Clearing it aborts reception, holds flags
// - Receiver enable zero on reset/io halt
// - Transmit enable bit 5; clear aborts, keeps empty
// - Transmit enable zero on reset/io halt
// - Channel 0 bit 4 drives request-to-send
// - Bit 3 reads last multiprocessor bit (here only in mp format, else zero)
// - Writing zero to bit 3 clears errors
// - Bit 3 reset value is undefined
// - Bits 2..0 select length, parity, stops
// - Wake-up enable ignored without multiprocessor format
// - Wake-up on: only mp-bit characters update flags
// - Wake-up off: every character updates flags
// - Channel 1 bit 4 is clock-pin disable
// - Clock-pin disable picks DMA end output
// - Multiprocessor frame has mp bit, no parity
// - Receive interrupt on any receive flag rising
//
// The APB register port was chosen for this implementation.
`default_nettype none
module ascca_top #(
  parameter int NCH = 2                                  // Number of serial channels
) (
  input  wire logic                         I_MCLK,
  input  wire logic                         I_RST,
  input  wire logic                         I_PSEL,
  input  wire logic                         I_PENABLE,
  input  wire logic                         I_PWRITE,
  input  wire logic [ascca_pkg::ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]                  I_PWDATA,
  output logic      [31:0]                  O_PRDATA,
  output logic                              O_PREADY,
  output logic                              O_PSLVERR,
  input  wire logic                         I_IO_HALT,    // I/O-stop mode
  input  wire ascca_pkg::ascca_rxev_t       I_RX_EV [NCH], // Character received
  input  wire logic                         I_DMA_END,    // DMA end-of-transfer source
  input  wire logic                         I_CLK1_OUT,   // Channel-1 clock when driven
  input  wire logic                         I_CLK1_OE,    // Channel-1 clock drive request
  input  wire logic                         I_CLK1_PIN_I, // Shared pin level
  output logic                              O_CLK1_PIN_O,
  output logic                              O_CLK1_PIN_OE,
  output logic                              O_CLK1_IN,    // External clock to channel 1
  output logic                              O_REQUEST_TO_SEND_CH0_N,     // Request-to-send, low active
  output logic      [NCH-1:0]               O_RX_EN,
  output logic      [NCH-1:0]               O_TX_EN,
  output ascca_pkg::ascca_fmt_t             O_FMT [NCH],
  output logic                              O_IRQ
);

  // Access phase decode
  // Writes land in the access cycle, which is also the cycle that shows
  // pready high, so a write and its answer always share one clock edge.
  // Unaligned byte addresses match nothing and are refused like holes.
  wire                 acc      = I_PSEL & I_PENABLE;
  wire                 wr       = acc & I_PWRITE;
  wire [9:0]           idx      = I_PADDR[11:2];
  wire                 aligned  = (I_PADDR[1:0] == 2'h0);
  wire [7:0]           wb       = I_PWDATA[7:0];
  wire                 sel_a0   = aligned && idx == 10'(ascca_pkg::CTRL_A_CH0_IDX);
  wire                 sel_a1   = aligned && idx == 10'(ascca_pkg::CTRL_A_CH1_IDX);
  wire                 sel_b0   = aligned && idx == 10'(ascca_pkg::CTRL_B_CH0_IDX);
  wire                 sel_b1   = aligned && idx == 10'(ascca_pkg::CTRL_B_CH1_IDX);
  wire                 sel_st   = aligned && idx == 10'(ascca_pkg::INT_STAT_IDX);
  wire                 sel_mk   = aligned && idx == 10'(ascca_pkg::INT_MASK_IDX);
  wire                 sel_fl   = aligned && idx == 10'(ascca_pkg::RX_FLAGS_IDX);
  wire                 mapped   = sel_a0 | sel_a1 | sel_b0 | sel_b1 | sel_st | sel_mk | sel_fl;

  logic [7:0]          ctrl_a [NCH];        // Control register A per channel
  logic [7:0]          ctrl_b [NCH];        // Control register B (mp select only used)
  logic [NCH-1:0]      mp_last;             // Last received multiprocessor bit
  logic [ascca_pkg::NFLG-1:0] flags [NCH];  // Receive full and error flags
  logic [7:0]          int_stat;            // Sticky events, 4 per channel
  logic [7:0]          int_mask;
  logic [7:0]          rd_mux;
  wire  [NCH-1:0]      sel_a    = {sel_a1, sel_a0};
  wire  [NCH-1:0]      sel_b    = {sel_b1, sel_b0};
  logic [7:0]          flg_rise;            // Flags going to one this cycle

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Wake-up filter only counts with multiprocessor format on
      wire mp_fmt  = ctrl_b[g][ascca_pkg::BIT_MPSEL];
      wire wake    = ctrl_a[g][ascca_pkg::BIT_WAKE] & mp_fmt;
      wire take    = I_RX_EV[g].valid & ctrl_a[g][ascca_pkg::BIT_RXEN]
                     & (~wake | I_RX_EV[g].mp_bit);
      wire error_flag_clear     = wr & sel_a[g] & ~wb[ascca_pkg::BIT_MPB];
      wire [ascca_pkg::NFLG-1:0] set_v = {I_RX_EV[g].framing_err,
                                          I_RX_EV[g].parity_err & ~mp_fmt,
                                          I_RX_EV[g].overrun, 1'b1} & {4{take}};
      wire [ascca_pkg::NFLG-1:0] clr_v = {error_flag_clear, error_flag_clear, error_flag_clear, 1'b0};
      // Set wins over the error clear when both land in one cycle
      wire [ascca_pkg::NFLG-1:0] next_flags = (flags[g] & ~clr_v) | set_v;

      // Control A; enables forced off in io halt, bit 3 not stored
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          ctrl_a[g] <= (g == 0) ? ascca_pkg::CTRL_A_CH0_RST : ascca_pkg::CTRL_A_CH1_RST;
        end else begin
          if (wr && sel_a[g]) begin
            ctrl_a[g] <= wb & ~8'h08;
          end
          if (I_IO_HALT) begin
            ctrl_a[g][ascca_pkg::BIT_RXEN] <= 1'b0;
            ctrl_a[g][ascca_pkg::BIT_TXEN] <= 1'b0;
          end
        end
      end

      // Control B, reset clears multiprocessor select
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          ctrl_b[g] <= ascca_pkg::CTRL_B_RST;
        end else if (wr && sel_b[g]) begin
          ctrl_b[g] <= wb;
        end
      end

      // Flags held when receiver disabled: only accepted characters set them
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          flags[g]   <= '0;
          mp_last[g] <= 1'b0;
        end else begin
          flags[g] <= next_flags;
          if (take) begin
            mp_last[g] <= I_RX_EV[g].mp_bit;
          end
        end
      end
      assign flg_rise[4*g +: 4] = next_flags & ~flags[g];

      // Frame format out, parity suppressed in multiprocessor frames
      always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
          O_FMT[g]   <= '0;
          O_RX_EN[g] <= 1'b0;
          O_TX_EN[g] <= 1'b0;
        end else begin
          O_FMT[g].eight_bits <= ctrl_a[g][ascca_pkg::BIT_FMT_H];
          O_FMT[g].parity_on  <= ctrl_a[g][1] & ~mp_fmt;
          O_FMT[g].two_stops  <= ctrl_a[g][0];
          O_FMT[g].mp_frame   <= mp_fmt;
          O_RX_EN[g] <= ctrl_a[g][ascca_pkg::BIT_RXEN] & ~I_IO_HALT;
          O_TX_EN[g] <= ctrl_a[g][ascca_pkg::BIT_TXEN] & ~I_IO_HALT;
        end
      end
    end
  endgenerate

  // Read mux; bit 3 of control A returns last mp bit in mp format
  // Bit 3 is never stored: a written zero only pulses the error clear.
  // Outside mp format bit 3 reads zero, so software must not rely on it.
  // Unselected addresses fall through to zero read data.
  always_comb begin
    rd_mux = 8'h00;
    if (sel_a0) rd_mux = ctrl_a[0] | {4'h0, mp_last[0] & ctrl_b[0][6], 3'h0};
    if (sel_a1) rd_mux = ctrl_a[1] | {4'h0, mp_last[1] & ctrl_b[1][6], 3'h0};
    if (sel_b0) rd_mux = ctrl_b[0];
    if (sel_b1) rd_mux = ctrl_b[1];
    if (sel_st) rd_mux = int_stat;
    if (sel_mk) rd_mux = int_mask;
    if (sel_fl) rd_mux = {flags[1], flags[0]};
  end

  // APB answer: zero wait, unmapped gives error
  // Ready is registered from the setup cycle, so it stands exactly in the
  // access cycle; read data is captured from the setup-cycle address.
  // Trade-off: one flop stage keeps outputs clean at no wait-state cost.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA  <= 32'h0000_0000;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= I_PSEL & ~I_PENABLE & ~mapped;
      O_PRDATA  <= {24'h00_0000, rd_mux};
    end
  end

  // Sticky status, write one clears, set wins
  // Status follows flag rising edges, not levels, so a flag that stays
  // set after a clear does not raise the event again.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      int_stat <= 8'h00;
      int_mask <= 8'h00;
    end else begin
      int_stat <= (int_stat & ~((wr && sel_st) ? wb : 8'h00)) | flg_rise;
      if (wr && sel_mk) int_mask <= wb;
    end
  end

  // Pins: request-to-send and shared clock / DMA-end pin
  // The shared pin is driven only in DMA-end mode or on channel-1 request;
  // the clock seen by channel 1 is held low while the pin is given away.
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ         <= 1'b0;
      O_REQUEST_TO_SEND_CH0_N      <= 1'b1;
      O_CLK1_PIN_O  <= 1'b0;
      O_CLK1_PIN_OE <= 1'b0;
      O_CLK1_IN     <= 1'b0;
    end else begin
      O_IRQ    <= |(int_stat & int_mask);
      O_REQUEST_TO_SEND_CH0_N <= ctrl_a[0][ascca_pkg::BIT_PIN4];
      if (ctrl_a[1][ascca_pkg::BIT_PIN4]) begin
        O_CLK1_PIN_O  <= I_DMA_END;
        O_CLK1_PIN_OE <= 1'b1;
        O_CLK1_IN     <= 1'b0;
      end else begin
        O_CLK1_PIN_O  <= I_CLK1_OUT;
        O_CLK1_PIN_OE <= I_CLK1_OE;
        O_CLK1_IN     <= I_CLK1_PIN_I;
      end
    end
  end

  // Assertions
  a_rx_halt_off: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_IO_HALT |=> !O_RX_EN[0] && !O_RX_EN[1]) else $error("rx enabled in halt");
  a_tx_halt_off: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_IO_HALT |=> !O_TX_EN[0] && !O_TX_EN[1]) else $error("tx enabled in halt");
  a_rts_follow: assert property (@(posedge I_MCLK) disable iff (I_RST)
    wr && sel_a0 |=> ##1 O_REQUEST_TO_SEND_CH0_N == $past(wb[4], 2)) else $error("rts mismatch");
  a_efr_clears: assert property (@(posedge I_MCLK) disable iff (I_RST)
    wr && sel_a0 && !wb[3] && !I_RX_EV[0].valid |=> flags[0][3:1] == 3'h0)
    else $error("errors not cleared");
  a_wake_filter: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl_a[0][7] && ctrl_b[0][6] && I_RX_EV[0].valid && !I_RX_EV[0].mp_bit
    && !(wr && sel_a0) |=> flags[0] == $past(flags[0])) else $error("wake filter leak");
  a_all_take: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !ctrl_a[0][7] && ctrl_a[0][6] && I_RX_EV[0].valid |=> flags[0][0])
    else $error("char not taken");
  a_rx_hold: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !ctrl_a[1][6] && !(wr && sel_a1) |=> flags[1] == $past(flags[1]))
    else $error("flags changed when off");
  a_pin_dma: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl_a[1][4] |=> O_CLK1_PIN_OE && O_CLK1_PIN_O == $past(I_DMA_END))
    else $error("pin not dma end");
  a_rx_irq: assert property (@(posedge I_MCLK) disable iff (I_RST)
    flg_rise[0] && int_mask[0] |=> ##1 O_IRQ) else $error("no rx interrupt");

  // Bus-side sequences: a setup cycle to a mapped or an unmapped place
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  sequence s_setup_bad;
    I_PSEL && !I_PENABLE && !mapped;
  endsequence
  sequence s_setup_good;
    I_PSEL && !I_PENABLE && mapped;
  endsequence

  // Every setup cycle is answered in the next cycle
  a_ready_pulse: assert property (@(posedge I_MCLK) disable iff (I_RST)
    s_setup |=> O_PREADY) else $error("no ready after setup");

  // Ready stands one cycle only
  a_ready_single: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_PREADY |=> !O_PREADY) else $error("ready held too long");

  // Holes are refused with an error
  a_err_unmapped: assert property (@(posedge I_MCLK) disable iff (I_RST)
    s_setup_bad |=> O_PSLVERR && O_PREADY) else $error("hole not refused");

  // Mapped places answer without error
  a_err_quiet: assert property (@(posedge I_MCLK) disable iff (I_RST)
    s_setup_good |=> !O_PSLVERR) else $error("error on mapped place");

  // Holes read as zero
  a_unmapped_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
    s_setup_bad |=> O_PRDATA == 32'h0000_0000) else $error("hole read not zero");

  // Registers are eight bits wide; upper read bits stay zero
  a_prdata_hi: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_PRDATA[31:8] == 24'h00_0000) else $error("upper read bits set");

  // Channel 0 format follows its control bits one edge later
  a_fmt_follow0: assert property (@(posedge I_MCLK) disable iff (I_RST)
    1'b1 |=> O_FMT[0].eight_bits == $past(ctrl_a[0][2])
    && O_FMT[0].two_stops == $past(ctrl_a[0][0])) else $error("format ch0 wrong");

  // Channel 1 format follows its control bits one edge later
  a_fmt_follow1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    1'b1 |=> O_FMT[1].eight_bits == $past(ctrl_a[1][2])
    && O_FMT[1].two_stops == $past(ctrl_a[1][0])) else $error("format ch1 wrong");

  // Multiprocessor frames carry no parity bit
  a_parity_mp: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl_b[0][6] |=> O_FMT[0].mp_frame && !O_FMT[0].parity_on)
    else $error("parity in mp frame");

  // Channel 0 receiver enable follows its bit outside halt
  a_rx_follow0: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !I_IO_HALT |=> O_RX_EN[0] == $past(ctrl_a[0][6])) else $error("rx ch0 enable wrong");

  // Channel 0 transmitter enable follows its bit outside halt
  a_tx_follow0: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !I_IO_HALT |=> O_TX_EN[0] == $past(ctrl_a[0][5])) else $error("tx ch0 enable wrong");

  // Channel 1 receiver enable follows its bit outside halt
  a_rx_follow1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !I_IO_HALT |=> O_RX_EN[1] == $past(ctrl_a[1][6])) else $error("rx ch1 enable wrong");

  // Channel 1 transmitter enable follows its bit outside halt
  a_tx_follow1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !I_IO_HALT |=> O_TX_EN[1] == $past(ctrl_a[1][5])) else $error("tx ch1 enable wrong");

  // Clock mode: the pin belongs to channel 1 in both directions
  a_clk_in: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !ctrl_a[1][4] |=> O_CLK1_IN == $past(I_CLK1_PIN_I)
    && O_CLK1_PIN_OE == $past(I_CLK1_OE) && O_CLK1_PIN_O == $past(I_CLK1_OUT))
    else $error("pin not channel clock");

  // DMA-end mode: channel 1 sees no external clock
  a_dma_no_in: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl_a[1][4] |=> !O_CLK1_IN) else $error("clock leaks in dma mode");

  // A status bit stays until software writes a one to it
  a_stat_sticky: assert property (@(posedge I_MCLK) disable iff (I_RST)
    int_stat[0] && !(wr && sel_st && wb[0]) |=> int_stat[0]) else $error("status lost");

  // Writing a one clears a status bit when no new event comes
  a_stat_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
    wr && sel_st && wb[0] && !flg_rise[0] |=> !int_stat[0]) else $error("status not cleared");

  // Mask takes the written byte
  a_mask_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
    wr && sel_mk |=> int_mask == $past(wb)) else $error("mask not written");

  // Fully masked status never raises the interrupt
  a_irq_quiet: assert property (@(posedge I_MCLK) disable iff (I_RST)
    int_mask == 8'h00 |=> !O_IRQ) else $error("masked interrupt raised");

  // An accepted character leaves its multiprocessor bit for read-back
  a_mp_capture: assert property (@(posedge I_MCLK) disable iff (I_RST)
    I_RX_EV[0].valid && ctrl_a[0][6] && !(ctrl_a[0][7] && ctrl_b[0][6])
    |=> mp_last[0] == $past(I_RX_EV[0].mp_bit)) else $error("mp bit not captured");

  // Error clear on channel 1 as well
  a_efr_ch1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    wr && sel_a1 && !wb[3] && !I_RX_EV[1].valid |=> flags[1][3:1] == 3'h0)
    else $error("ch1 errors not cleared");

  // Channel 1 wake-up filter drops characters without the mp bit
  a_wake_filter1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ctrl_a[1][7] && ctrl_b[1][6] && I_RX_EV[1].valid && !I_RX_EV[1].mp_bit
    && !(wr && sel_a1) |=> flags[1] == $past(flags[1])) else $error("ch1 wake leak");

  // Channel 1 takes every character with wake-up off
  a_all_take1: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !ctrl_a[1][7] && ctrl_a[1][6] && I_RX_EV[1].valid |=> flags[1][0])
    else $error("ch1 char not taken");

endmodule // ascca_top
`default_nettype wire
